// File: rtl/sfd_pkg.sv
package sfd_pkg;

  // ------------------------------------------------------------
  // Register map and field layout
  // ------------------------------------------------------------
  localparam logic [7:0] SFD_OFS_CTRL = 8'h00;
  localparam logic [7:0] SFD_OFS_DST = 8'h04;
  localparam logic [7:0] SFD_OFS_SRC = 8'h08;
  localparam logic [7:0] SFD_OFS_FLAGS = 8'h0c;
  localparam logic [7:0] SFD_OFS_CMD = 8'h10;
  localparam logic [7:0] SFD_OFS_STATUS = 8'h14;

  localparam int SFD_CTRL_SIZE_LSB = 0;
  localparam int SFD_CTRL_FORM_LSB = 2;
  localparam int SFD_CTRL_PORT = 4;
  localparam int SFD_CTRL_BIN = 5;
  localparam int SFD_CMD_ESC = 8;

  localparam int SFD_FL_BORROW = 0;
  localparam int SFD_FL_HALF = 1;
  localparam int SFD_FL_RANGE = 2;
  localparam int SFD_FL_SIGN = 3;
  localparam int SFD_FL_ZERO = 4;

  localparam int SFD_ST_BUSY = 0;
  localparam int SFD_ST_BAD = 1;
  localparam int SFD_ST_BYTES_LSB = 8;
  localparam int SFD_ST_STATES_LSB = 12;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] SFD_CTRL_RST = 8'h00;
  localparam logic [4:0] SFD_FLAGS_RST = 5'h00;
  localparam logic [31:0] SFD_DATA_RST = 32'h0;
  localparam logic [3:0] SFD_CNT_RST = 4'h0;

  // ------------------------------------------------------------
  // Operand sizes, source forms, opcodes
  // ------------------------------------------------------------
  localparam logic [1:0] SFD_SZ_BYTE = 2'h0;
  localparam logic [1:0] SFD_SZ_WORD = 2'h1;
  localparam logic [1:0] SFD_SZ_DWORD = 2'h2;
  localparam logic [1:0] SFD_FM_IMM = 2'h0;
  localparam logic [1:0] SFD_FM_IND = 2'h1;
  localparam logic [1:0] SFD_FM_REG = 2'h2;
  localparam logic [1:0] SFD_FM_DIR = 2'h3;

  localparam logic [7:0] SFD_OPC_BRW_IMM = 8'h94;
  localparam logic [7:0] SFD_OPC_BRW_DIR = 8'h95;
  localparam logic [6:0] SFD_OPC_BRW_IND = 7'h4b;
  localparam logic [4:0] SFD_OPC_BRW_REG = 5'h13;
  localparam logic [7:0] SFD_OPC_SUB_BYTE = 8'h9c;
  localparam logic [7:0] SFD_OPC_SUB_WORD = 8'h9d;
  localparam logic [7:0] SFD_OPC_SUB_EXT = 8'h9e;
  localparam logic [7:0] SFD_OPC_SUB_DWORD = 8'h9f;

  // ------------------------------------------------------------
  // Base lengths in bytes and states, before escape and port costs
  // ------------------------------------------------------------
  localparam logic [3:0] SFD_LEN_SHORT = 4'h1;
  localparam logic [3:0] SFD_LEN_TWO = 4'h2;
  localparam logic [3:0] SFD_LEN_THREE = 4'h3;
  localparam logic [3:0] SFD_LEN_FOUR = 4'h4;
  localparam logic [3:0] SFD_LEN_FIVE = 4'h5;

  typedef enum logic [1:0] {
    SFD_IDLE = 2'h1,
    SFD_RUN = 2'h2
  } sfd_state_type;

endpackage

// File: rtl/sfd_sub_slice.sv
`timescale 1ns/1ps
module sfd_sub_slice (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic bin,
  output logic [7:0] d,
  output logic bout3,
  output logic bout6,
  output logic bout7
);

  // ------------------------------------------------------------
  // One byte of difference with its internal borrows
  // ------------------------------------------------------------
  logic [4:0] lo;
  logic [7:0] mid;
  logic [8:0] full;

  assign lo = {1'h0, a[3:0]} - {1'h0, b[3:0]} - {4'h0, bin};
  assign mid = {1'h0, a[6:0]} - {1'h0, b[6:0]} - {7'h0, bin};
  assign full = {1'h0, a} - {1'h0, b} - {8'h0, bin};
  assign d = full[7:0];
  assign bout3 = lo[4];
  assign bout6 = mid[7];
  assign bout7 = full[8];

endmodule

// File: rtl/sfd_state_timer.sv
`timescale 1ns/1ps
module sfd_state_timer #(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done
);

  // ------------------------------------------------------------
  // Counts execution states, one state per clock
  // ------------------------------------------------------------
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_val;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done = (count == W'(1));

endmodule

// File: rtl/sfd_core.sv
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - Plain subtract writes destination minus source back into destination
// - Plain byte subtract sets borrow on borrow out of bit 7
// - Signed range flag marks sign-crossing subtraction results
// - Word and double-word subtract leave half-borrow unchanged
// - Plain subtract takes immediate, indirect, register, direct sources
// - Borrow subtract removes source and borrow flag from accumulator
// - Borrow subtract sets borrow on borrow out of bit 7
// - Borrow subtract sets half-borrow on borrow out of bit 3
// - Range flag is borrow into bit 7 xor borrow out of bit 7
// - Borrow subtract takes register, direct, indirect, immediate sources
// - Direct operand on an I/O port adds one state
// - Byte register subtract 9c: binary 3 bytes 2 states, source 2/1
module sfd_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0] ctrl;
  logic [31:0] dst;
  logic [31:0] src;
  logic [4:0] fl;
  logic bad;
  sfd_pkg::sfd_state_type state;
  logic run_brw;
  logic [1:0] run_size;
  logic [3:0] run_bytes;
  logic [3:0] run_states;
  logic [7:0] next_ctrl;
  logic [31:0] next_dst;
  logic [31:0] next_src;
  logic [4:0] next_fl;
  logic next_bad;
  sfd_pkg::sfd_state_type next_state;
  logic next_run_brw;
  logic [1:0] next_run_size;
  logic [3:0] next_run_bytes;
  logic [3:0] next_run_states;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  logic busy;
  logic wr;
  logic start;
  logic commit;
  logic done;
  logic cin;
  logic [31:0] res;
  logic [3:0] bi;
  logic [3:0] b3;
  logic [3:0] b6;
  logic [3:0] b7;
  logic [7:0] opc;
  logic esc;
  logic ext;
  logic port_hit;
  logic dec_valid;
  logic dec_brw;
  logic [1:0] dec_size;
  logic [1:0] dec_form;
  logic [3:0] base_b;
  logic [3:0] base_s;
  logic [3:0] dec_bytes;
  logic [3:0] dec_states;
  logic [1:0] c_size;
  logic [1:0] c_form;

  assign busy = (state == sfd_pkg::SFD_RUN);
  // Write lands only on the completing edge, and only if not refused
  assign wr = psel & penable & pready & pwrite & ~pslverr;
  assign start = wr & (paddr == sfd_pkg::SFD_OFS_CMD) & dec_valid;
  assign commit = busy & done;
  assign opc = pwdata[7:0];
  assign esc = pwdata[sfd_pkg::SFD_CMD_ESC];
  assign c_size = ctrl[sfd_pkg::SFD_CTRL_SIZE_LSB +: 2];
  assign c_form = ctrl[sfd_pkg::SFD_CTRL_FORM_LSB +: 2];

  // ------------------------------------------------------------
  // Instruction decode
  // ------------------------------------------------------------
  // Extended forms sit behind the escape byte in binary mode only
  assign ext = ctrl[sfd_pkg::SFD_CTRL_BIN] ? esc : ~esc;

  always_comb begin
    dec_valid = 1'h0;
    dec_brw = 1'h0;
    dec_size = sfd_pkg::SFD_SZ_BYTE;
    dec_form = sfd_pkg::SFD_FM_REG;
    base_b = sfd_pkg::SFD_LEN_SHORT;
    base_s = sfd_pkg::SFD_LEN_SHORT;
    if (opc == sfd_pkg::SFD_OPC_BRW_IMM) begin
      dec_valid = ~esc;
      dec_brw = 1'h1;
      dec_form = sfd_pkg::SFD_FM_IMM;
      base_b = sfd_pkg::SFD_LEN_TWO;
    end else if (opc == sfd_pkg::SFD_OPC_BRW_DIR) begin
      dec_valid = ~esc;
      dec_brw = 1'h1;
      dec_form = sfd_pkg::SFD_FM_DIR;
      base_b = sfd_pkg::SFD_LEN_TWO;
    end else if (!ext) begin
      if (opc[7:1] == sfd_pkg::SFD_OPC_BRW_IND) begin
        dec_valid = 1'h1;
        dec_brw = 1'h1;
        dec_form = sfd_pkg::SFD_FM_IND;
        base_s = sfd_pkg::SFD_LEN_TWO;
      end else if (opc[7:3] == sfd_pkg::SFD_OPC_BRW_REG) begin
        dec_valid = 1'h1;
        dec_brw = 1'h1;
      end
    end else begin
      base_b = sfd_pkg::SFD_LEN_TWO;
      unique case (opc)
        sfd_pkg::SFD_OPC_SUB_BYTE: begin
          dec_valid = 1'h1;
        end
        sfd_pkg::SFD_OPC_SUB_WORD: begin
          dec_valid = 1'h1;
          dec_size = sfd_pkg::SFD_SZ_WORD;
          base_s = sfd_pkg::SFD_LEN_TWO;
        end
        sfd_pkg::SFD_OPC_SUB_DWORD: begin
          dec_valid = 1'h1;
          dec_size = sfd_pkg::SFD_SZ_DWORD;
          base_s = sfd_pkg::SFD_LEN_FOUR;
        end
        sfd_pkg::SFD_OPC_SUB_EXT: begin
          dec_size = c_size;
          dec_form = c_form;
          base_b = sfd_pkg::SFD_LEN_THREE;
          base_s = sfd_pkg::SFD_LEN_TWO;
          unique case (c_form)
            sfd_pkg::SFD_FM_IMM: begin
              dec_valid = (c_size != 2'h3);
              if (c_size == sfd_pkg::SFD_SZ_WORD) begin
                base_b = sfd_pkg::SFD_LEN_FOUR;
                base_s = sfd_pkg::SFD_LEN_FOUR;
              end else if (c_size == sfd_pkg::SFD_SZ_DWORD) begin
                base_b = sfd_pkg::SFD_LEN_FOUR;
                base_s = sfd_pkg::SFD_LEN_FIVE;
              end
            end
            sfd_pkg::SFD_FM_DIR: begin
              dec_valid = (c_size == sfd_pkg::SFD_SZ_BYTE) |
                          (c_size == sfd_pkg::SFD_SZ_WORD);
              if (c_size == sfd_pkg::SFD_SZ_WORD) begin
                base_s = sfd_pkg::SFD_LEN_THREE;
              end
            end
            sfd_pkg::SFD_FM_IND: begin
              dec_valid = (c_size == sfd_pkg::SFD_SZ_BYTE);
              base_s = sfd_pkg::SFD_LEN_THREE;
            end
            default: begin
              dec_valid = 1'h0;
            end
          endcase
        end
        default: begin
          dec_valid = 1'h0;
        end
      endcase
    end
  end

  // A port read through a direct address stalls one more state
  assign port_hit = (dec_form == sfd_pkg::SFD_FM_DIR) &
                    ctrl[sfd_pkg::SFD_CTRL_PORT];
  assign dec_bytes = base_b + {3'h0, esc};
  assign dec_states = base_s + {3'h0, esc} + {3'h0, port_hit};

  // ------------------------------------------------------------
  // Datapath: four byte slices chained by borrow
  // ------------------------------------------------------------
  assign cin = run_brw & fl[sfd_pkg::SFD_FL_BORROW];
  assign bi = {b7[2:0], cin};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_slice
      sfd_sub_slice u_slice (
        .a(dst[8*g +: 8]),
        .b(src[8*g +: 8]),
        .bin(bi[g]),
        .d(res[8*g +: 8]),
        .bout3(b3[g]),
        .bout6(b6[g]),
        .bout7(b7[g])
      );
    end
  endgenerate

  sfd_state_timer #(
    .W(4)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(start),
    .load_val(dec_states),
    .done(done)
  );

  // ------------------------------------------------------------
  // Registers and execution
  // ------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_dst = dst;
    next_src = src;
    next_fl = fl;
    next_bad = bad;
    next_state = state;
    next_run_brw = run_brw;
    next_run_size = run_size;
    next_run_bytes = run_bytes;
    next_run_states = run_states;
    if (wr) begin
      if (paddr == sfd_pkg::SFD_OFS_CTRL) begin
        next_ctrl = pwdata[7:0];
      end
      if (paddr == sfd_pkg::SFD_OFS_DST) begin
        next_dst = pwdata;
      end
      if (paddr == sfd_pkg::SFD_OFS_SRC) begin
        next_src = pwdata;
      end
      if (paddr == sfd_pkg::SFD_OFS_FLAGS) begin
        next_fl = pwdata[4:0];
      end
      if (paddr == sfd_pkg::SFD_OFS_CMD) begin
        next_bad = ~dec_valid;
        if (dec_valid) begin
          next_state = sfd_pkg::SFD_RUN;
          next_run_brw = dec_brw;
          next_run_size = dec_size;
          next_run_bytes = dec_bytes;
          next_run_states = dec_states;
        end
      end
    end
    if (commit) begin
      next_state = sfd_pkg::SFD_IDLE;
      unique case (run_size)
        sfd_pkg::SFD_SZ_BYTE: begin
          next_dst[7:0] = res[7:0];
          next_fl[sfd_pkg::SFD_FL_BORROW] = b7[0];
          next_fl[sfd_pkg::SFD_FL_HALF] = b3[0];
          next_fl[sfd_pkg::SFD_FL_RANGE] = b6[0] ^ b7[0];
          next_fl[sfd_pkg::SFD_FL_SIGN] = res[7];
          next_fl[sfd_pkg::SFD_FL_ZERO] = (res[7:0] == 8'h0);
        end
        sfd_pkg::SFD_SZ_WORD: begin
          // Half-borrow is kept for wide operands
          next_dst[15:0] = res[15:0];
          next_fl[sfd_pkg::SFD_FL_BORROW] = b7[1];
          next_fl[sfd_pkg::SFD_FL_RANGE] = b6[1] ^ b7[1];
          next_fl[sfd_pkg::SFD_FL_SIGN] = res[15];
          next_fl[sfd_pkg::SFD_FL_ZERO] = (res[15:0] == 16'h0);
        end
        default: begin
          next_dst = res;
          next_fl[sfd_pkg::SFD_FL_BORROW] = b7[3];
          next_fl[sfd_pkg::SFD_FL_RANGE] = b6[3] ^ b7[3];
          next_fl[sfd_pkg::SFD_FL_SIGN] = res[31];
          next_fl[sfd_pkg::SFD_FL_ZERO] = (res == 32'h0);
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= sfd_pkg::SFD_CTRL_RST;
      dst <= sfd_pkg::SFD_DATA_RST;
      src <= sfd_pkg::SFD_DATA_RST;
      fl <= sfd_pkg::SFD_FLAGS_RST;
      bad <= 1'h0;
      state <= sfd_pkg::SFD_IDLE;
      run_brw <= 1'h0;
      run_size <= sfd_pkg::SFD_SZ_BYTE;
      run_bytes <= sfd_pkg::SFD_CNT_RST;
      run_states <= sfd_pkg::SFD_CNT_RST;
    end else begin
      ctrl <= next_ctrl;
      dst <= next_dst;
      src <= next_src;
      fl <= next_fl;
      bad <= next_bad;
      state <= next_state;
      run_brw <= next_run_brw;
      run_size <= next_run_size;
      run_bytes <= next_run_bytes;
      run_states <= next_run_states;
    end
  end

  // ------------------------------------------------------------
  // APB slave, one wait state per access
  // ------------------------------------------------------------
  always_comb begin
    logic mapped;
    mapped = 1'h0;
    next_pready = psel & penable & ~pready;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (psel & penable & ~pready) begin
      mapped = (paddr == sfd_pkg::SFD_OFS_CTRL) |
               (paddr == sfd_pkg::SFD_OFS_DST) |
               (paddr == sfd_pkg::SFD_OFS_SRC) |
               (paddr == sfd_pkg::SFD_OFS_FLAGS) |
               (paddr == sfd_pkg::SFD_OFS_CMD) |
               (paddr == sfd_pkg::SFD_OFS_STATUS);
      // Operands are frozen while busy, so every write is refused
      next_pslverr = ~mapped | (pwrite & busy);
      next_prdata = 32'h0;
      if (!pwrite) begin
        unique case (paddr)
          sfd_pkg::SFD_OFS_CTRL: next_prdata = {24'h0, ctrl};
          sfd_pkg::SFD_OFS_DST: next_prdata = dst;
          sfd_pkg::SFD_OFS_SRC: next_prdata = src;
          sfd_pkg::SFD_OFS_FLAGS: next_prdata = {27'h0, fl};
          sfd_pkg::SFD_OFS_STATUS: next_prdata = {16'h0, run_states,
                                                  run_bytes, 6'h0, bad,
                                                  busy};
          default: next_prdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'h0;
      pslverr <= 1'h0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [3:0] elapsed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed <= 4'h0;
    end else if (start) begin
      elapsed <= 4'h1;
    end else if (busy) begin
      elapsed <= elapsed + 4'h1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_sub_dword_result: assert property (
    commit & ~run_brw & (run_size == sfd_pkg::SFD_SZ_DWORD)
    |=> dst == $past(dst) - $past(src))
    else $error("dword difference wrong");
  a_byte_borrow_out: assert property (
    commit & ~run_brw & (run_size == sfd_pkg::SFD_SZ_BYTE)
    |=> fl[sfd_pkg::SFD_FL_BORROW] == ($past(dst[7:0]) < $past(src[7:0])))
    else $error("byte borrow wrong");
  a_range_sign_cross: assert property (
    commit & (run_size == sfd_pkg::SFD_SZ_BYTE)
    |=> fl[sfd_pkg::SFD_FL_RANGE] == (($past(dst[7]) != $past(src[7])) &&
        (dst[7] != $past(dst[7]))))
    else $error("range flag wrong");
  a_half_wide_hold: assert property (
    commit & (run_size != sfd_pkg::SFD_SZ_BYTE)
    |=> $stable(fl[sfd_pkg::SFD_FL_HALF]))
    else $error("half borrow changed on wide op");
  a_borrow_sub_value: assert property (
    commit & run_brw
    |=> dst[7:0] == $past(dst[7:0]) - $past(src[7:0]) - {7'h0, $past(cin)})
    else $error("borrow subtract value wrong");
  a_borrow_sub_carry: assert property (
    commit & run_brw
    |=> fl[sfd_pkg::SFD_FL_BORROW] == ({1'h0, $past(dst[7:0])} <
        {1'h0, $past(src[7:0])} + {8'h0, $past(cin)}))
    else $error("borrow subtract carry wrong");
  a_half_nibble: assert property (
    commit & run_brw
    |=> fl[sfd_pkg::SFD_FL_HALF] == ({1'h0, $past(dst[3:0])} <
        {1'h0, $past(src[3:0])} + {4'h0, $past(cin)}))
    else $error("half borrow wrong");
  a_state_count: assert property (
    commit |-> elapsed == run_states)
    else $error("execution length wrong");
  a_byte_reg_timing: assert property (
    start & (opc == sfd_pkg::SFD_OPC_SUB_BYTE) & ctrl[sfd_pkg::SFD_CTRL_BIN]
    |=> (run_bytes == sfd_pkg::SFD_LEN_THREE) &&
        (run_states == sfd_pkg::SFD_LEN_TWO) ##1 commit)
    else $error("byte register timing wrong");
  a_escape_needed: assert property (
    wr & (paddr == sfd_pkg::SFD_OFS_CMD) & ctrl[sfd_pkg::SFD_CTRL_BIN] &
    ~esc & (opc[7:3] == sfd_pkg::SFD_OPC_BRW_REG)
    |=> busy & run_brw & (run_bytes == sfd_pkg::SFD_LEN_SHORT))
    else $error("extended form taken without escape");
  a_flag_sign_zero: assert property (
    commit & (run_size == sfd_pkg::SFD_SZ_DWORD)
    |=> (fl[sfd_pkg::SFD_FL_SIGN] == dst[31]) &&
        (fl[sfd_pkg::SFD_FL_ZERO] == (dst == 32'h0)))
    else $error("sign or zero wrong");

  c_borrow_sub: cover property (commit & run_brw);
  c_dword_sub: cover property (commit & (run_size == sfd_pkg::SFD_SZ_DWORD));
  c_port_stall: cover property (start & port_hit);
  c_bus_refused: cover property (pready & pslverr);

endmodule

// File: testbench/sfd_core_tb.sv
`timescale 1ns/1ps
module sfd_core_tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rdata_q;
  logic err_q;
  int miscompares;
  int comparisons;

  sfd_core i_sfd_core (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  // ------------------------------------------------------------
  // Clock, reset and watchdog
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    repeat (8000) @(posedge pclk);
    miscompares++;
    results();
  end

  // ------------------------------------------------------------
  // Bus access and comparison
  // ------------------------------------------------------------
  // Entered just after an edge; keep leaves psel up for a
  // back-to-back setup so psel is never assigned twice in one step
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic keep);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    rdata_q = prdata;
    err_q = pslverr;
    penable <= 1'b0;
    if (!keep) begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0, 1'b0);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Busy is polled, never timed: the state count differs per form
  task automatic poll();
    int n;
    n = 0;
    do begin
      rd(sfd_pkg::SFD_OFS_STATUS);
      n++;
    end while (rdata_q[0] !== 1'b0 && n < 40);
    if (n >= 40) miscompares++;
  endtask

  task automatic run(input logic [31:0] c, input logic [31:0] cmd,
                     input logic [31:0] d, input logic [31:0] s,
                     input logic [31:0] f, input logic [31:0] ed,
                     input logic [31:0] ef, input logic [31:0] es);
    wr(sfd_pkg::SFD_OFS_CTRL, c);
    wr(sfd_pkg::SFD_OFS_DST, d);
    wr(sfd_pkg::SFD_OFS_SRC, s);
    wr(sfd_pkg::SFD_OFS_FLAGS, f);
    wr(sfd_pkg::SFD_OFS_CMD, cmd);
    poll();
    chk(rdata_q, es);
    rd(sfd_pkg::SFD_OFS_DST);
    chk(rdata_q, ed);
    rd(sfd_pkg::SFD_OFS_FLAGS);
    chk(rdata_q, ef);
  endtask

  task automatic results();
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    comparisons = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 6; a++) begin
      rd(8'(a * 4));
      chk(rdata_q, 32'h0);
    end
    // Byte register forms, source and binary mode
    run(32'h00, 32'h09c, 32'hc9, 32'h54, 32'h0,
        32'h75, 32'h04, 32'h1200);
    run(32'h20, 32'h19c, 32'h10, 32'h20, 32'h0,
        32'hf0, 32'h09, 32'h2300);
    // Borrow subtract over its source forms
    run(32'h20, 32'h09a, 32'hc9, 32'h54, 32'h1,
        32'h74, 32'h04, 32'h1100);
    run(32'h20, 32'h094, 32'h10, 32'h01, 32'h0,
        32'h0f, 32'h02, 32'h1200);
    run(32'h30, 32'h095, 32'h05, 32'h03, 32'h0,
        32'h02, 32'h00, 32'h2200);
    run(32'h20, 32'h096, 32'h00, 32'h00, 32'h1,
        32'hff, 32'h0b, 32'h2100);
    run(32'h20, 32'h09f, 32'h05, 32'h04, 32'h1,
        32'h00, 32'h10, 32'h1100);
    // Source mode reaches the indirect borrow form through the escape byte
    run(32'h00, 32'h197, 32'h40, 32'h41, 32'h0,
        32'hff, 32'h0b, 32'h3200);
    // Wide forms keep the half-borrow flag
    run(32'h00, 32'h09d, 32'h1234, 32'h1235, 32'h2,
        32'hffff, 32'h0b, 32'h2200);
    run(32'h00, 32'h09f, 32'h80000000, 32'h1, 32'h2,
        32'h7fffffff, 32'h06, 32'h4200);
    // Word direct touches only the low half; dword immediate
    run(32'h0d, 32'h09e, 32'habcd0100, 32'h1, 32'h0,
        32'habcd00ff, 32'h00, 32'h3300);
    run(32'h02, 32'h09e, 32'h1, 32'h2, 32'h0,
        32'hffffffff, 32'h09, 32'h5400);
    // Extended forms: immediate, and direct on a port
    run(32'h00, 32'h09e, 32'h05, 32'h07, 32'h0,
        32'hfe, 32'h0b, 32'h2300);
    run(32'h1c, 32'h09e, 32'h7f, 32'hff, 32'h0,
        32'h80, 32'h0d, 32'h3300);
    // Refused combinations leave the destination alone
    wr(sfd_pkg::SFD_OFS_CTRL, 32'h08);
    wr(sfd_pkg::SFD_OFS_DST, 32'h11);
    wr(sfd_pkg::SFD_OFS_CMD, 32'h09e);
    rd(sfd_pkg::SFD_OFS_STATUS);
    chk(rdata_q & 32'h2, 32'h2);
    rd(sfd_pkg::SFD_OFS_DST);
    chk(rdata_q, 32'h11);
    wr(sfd_pkg::SFD_OFS_CTRL, 32'h20);
    wr(sfd_pkg::SFD_OFS_CMD, 32'h194);
    rd(sfd_pkg::SFD_OFS_STATUS);
    chk(rdata_q & 32'h2, 32'h2);
    // Write during a run is refused without effect
    wr(sfd_pkg::SFD_OFS_CTRL, 32'h00);
    wr(sfd_pkg::SFD_OFS_DST, 32'h80000000);
    wr(sfd_pkg::SFD_OFS_SRC, 32'h1);
    xfer(1'b1, sfd_pkg::SFD_OFS_CMD, 32'h09f, 1'b1);
    wr(sfd_pkg::SFD_OFS_DST, 32'h55);
    chk(32'(err_q), 32'h1);
    poll();
    rd(sfd_pkg::SFD_OFS_DST);
    chk(rdata_q, 32'h7fffffff);
    // Unmapped address answers with an error and no data
    rd(8'h18);
    chk(rdata_q, 32'h0);
    chk(32'(err_q), 32'h1);
    results();
  end
endmodule
